// ==== onchip_map_pkg.sv ====
// onchip_map_pkg: memory map, register layout and field positions for the
// on-chip memory decoder and flash lock.
// assumes 16-bit program and data address spaces driven by one core.
package onchip_map_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_AW = 2;
  // dual-access ram: block zero, block one, block two in one array
  localparam int BLK_ZERO_WORDS = 256;
  localparam int BLK_ONE_WORDS = 256;
  localparam int BLK_TWO_WORDS = 32;
  localparam int DUAL_PORT_RAM_WORDS = 544;
  localparam int DUAL_PORT_RAM_AW = 10;
  localparam logic [9:0] BLK_ONE_IDX = 10'h100;
  localparam logic [9:0] BLK_TWO_IDX = 10'h200;
  localparam int SINGLE_PORT_RAM_WORDS = 512;
  localparam int SINGLE_PORT_RAM_AW = 9;
  // program space
  localparam logic [15:0] BOOT_BASE = 16'h0000;
  localparam int BOOT_WORDS = 256;
  localparam logic [15:0] FLASH_BASE = 16'h0000;
  localparam int FLASH_WORDS = 8192;
  localparam int FLASH_AW = 13;
  localparam int SECTOR_BIT = 12;
  localparam logic [15:0] SINGLE_PORT_RAM_PROG_BASE = 16'h8000;
  localparam logic [15:0] BLK_ZERO_PROG_BASE = 16'hfe00;
  // data space
  localparam logic [15:0] BLK_TWO_DATA_BASE = 16'h0060;
  localparam logic [15:0] BLK_ZERO_DATA_BASE = 16'h0200;
  localparam logic [15:0] BLK_ONE_DATA_BASE = 16'h0300;
  localparam logic [15:0] SINGLE_PORT_RAM_DATA_BASE = 16'h0800;
  // flash lock addresses
  localparam logic [15:0] KEY_READ_BASE = 16'h0040;
  localparam logic [15:0] PASSWORD_BASE = 16'h77f0;
  // register offsets
  localparam logic [1:0] REG_SYS_CTRL_TWO = 2'h0;
  localparam logic [1:0] REG_MEM_CTRL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  // system_control_two fields
  localparam int SAR_PROG_BIT = 0;
  localparam int SAR_DATA_BIT = 1;
  localparam int BOOT_EN_BIT = 3;
  localparam logic [1:0] SAR_MAP_RESET = 2'b11;
  // memory control fields
  localparam int BZ_SEL_BIT = 0;
  localparam int PROT_LSB = 1;
  // status fields
  localparam int STAT_SECURED_BIT = 0;
  localparam int STAT_X4_BIT = 1;
  localparam int STAT_STRAP_BIT = 2;
endpackage : onchip_map_pkg

// ==== ram_port_if.sv ====
// ram_port_if: one read port and one write port of an on-chip ram.
// assumes controller and memory share sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface ram_port_if #(
  parameter int AW = 10,
  parameter int DW = 16
);
  logic [AW-1:0] rd_addr;
  logic rd;
  logic [DW-1:0] rdata;
  logic [AW-1:0] wr_addr;
  logic wr;
  logic [DW-1:0] wdata;
  modport ctrl (output rd_addr, rd, wr_addr, wr, wdata, input rdata);
  modport mem (input rd_addr, rd, wr_addr, wr, wdata, output rdata);
endinterface : ram_port_if
`default_nettype wire

// ==== dual_access_mem.sv ====
// dual_access_mem: word memory with a read and a write in the same cycle.
// assumes the controller keeps addresses below WORDS.
`timescale 1ns/100ps
`default_nettype none
module dual_access_mem #(
  parameter int WORDS = 544,
  parameter int AW = 10,
  parameter int DW = 16
) (
  // clock
  input wire logic sys_clk,
  // access port
  ram_port_if.mem port
);
  logic [DW-1:0] store [WORDS];

  if (WORDS > (1 << AW)) begin : g_bad_size
    $error("dual_access_mem: WORDS does not fit AW");
  end

  // write port, no stall against the read
  always_ff @(posedge sys_clk) begin
    if (port.wr) begin
      store[port.wr_addr] <= port.wdata;
    end
  end

  // registered read port, old data on same-address collision
  always_ff @(posedge sys_clk) begin
    if (port.rd) begin
      port.rdata <= store[port.rd_addr];
    end
  end
endmodule : dual_access_mem
`default_nettype wire

// ==== flash_unlock.sv ====
// flash_unlock: key-read tracking and password compare for the flash lock.
// assumes key_words holds the four stored key words, word 0 lowest.
`timescale 1ns/100ps
`default_nettype none
module flash_unlock
  import onchip_map_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // observed core accesses
  input wire logic prog_rd,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic data_wr,
  input wire logic [ADDR_W-1:0] data_wr_addr,
  input wire logic [DATA_W-1:0] data_wdata,
  // stored key
  input wire logic [4*DATA_W-1:0] key_words,
  // lock state
  output logic secured
);
  logic [3:0] keys_seen;
  logic [1:0] pw_idx;
  logic unlock_go;
  logic key_hit;
  logic pw_hit;
  logic pw_match;
  logic keys_trivial;

  // address and compare terms
  assign key_hit = prog_rd && (prog_addr[15:2] == KEY_READ_BASE[15:2]);
  assign pw_hit = data_wr && (data_wr_addr[15:2] == PASSWORD_BASE[15:2]);
  assign pw_match = (data_wr_addr[1:0] == pw_idx) &&
                    (data_wdata == key_words[pw_idx*DATA_W +: DATA_W]);
  assign keys_trivial = (key_words == '0) || (&key_words);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      keys_seen <= 4'h0;
    end else if (key_hit) begin
      keys_seen[prog_addr[1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pw_idx <= 2'h0;
    end else if (pw_hit && (&keys_seen)) begin
      pw_idx <= pw_match ? pw_idx + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unlock_go <= 1'b0;
    end else begin
      unlock_go <= (&keys_seen) && (keys_trivial ||
                   (pw_hit && pw_match && (pw_idx == 2'h3)));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      secured <= 1'b1;
    end else if (unlock_go) begin
      secured <= 1'b0;
    end
  end
endmodule : flash_unlock
`default_nettype wire

// ==== onchip_memory_map.sv ====
// onchip_memory_map: decodes core program and data accesses onto the
// dual-access ram, single-access ram, flash and boot rom, with flash lock.
// assumes one core on sys_clk; flash and boot rom arrays answer in the cycle
// of their read strobe; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module onchip_memory_map
  import onchip_map_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // program bus
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [DATA_W-1:0] prog_wdata,
  output logic [DATA_W-1:0] prog_rdata,
  output logic prog_rvalid,
  // data bus
  input wire logic [ADDR_W-1:0] data_rd_addr,
  input wire logic data_rd,
  output logic [DATA_W-1:0] data_rdata,
  output logic data_rvalid,
  input wire logic [ADDR_W-1:0] data_wr_addr,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  // block zero set and clear instructions
  input wire logic blk_zero_set,
  input wire logic blk_zero_clr,
  // flash and boot rom arrays
  output logic [FLASH_AW-1:0] flash_addr,
  output logic flash_rd,
  output logic flash_wr,
  output logic [DATA_W-1:0] flash_wdata,
  input wire logic [DATA_W-1:0] flash_rdata,
  output logic [1:0] flash_sector_protect,
  output logic [7:0] boot_addr,
  output logic boot_rd,
  input wire logic [DATA_W-1:0] boot_rdata,
  input wire logic [4*DATA_W-1:0] key_words,
  // pins
  input wire logic ext_debug,
  input wire logic test_reset_pin,
  input wire logic device_reset_pin_n,
  input wire logic test_data_pin,
  input wire logic serial_transmit_pin,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // status
  output logic flash_secured,
  output logic pll_mult_x4,
  output logic boot_rom_active
);
  typedef enum {SRC_NONE, SRC_DAR, SRC_SAR, SRC_FLASH, SRC_BOOT,
                SRC_ZERO} src_e;

  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic single_port_ram_program_map;
  logic single_port_ram_data_map;
  logic boot_rom_enable;
  logic block_zero_space_select;
  logic boot_strap_seen;
  logic secured;
  logic boot_strap;
  logic ext_blocked;
  logic p_boot, p_flash, p_sar, p_bz;
  logic r_bz, r_b1, r_b2, r_sar;
  logic w_bz, w_b1, w_b2, w_sar;
  logic r_dar;
  logic [DUAL_PORT_RAM_AW-1:0] data_rd_idx;
  logic [DUAL_PORT_RAM_AW-1:0] data_wr_idx;
  src_e prog_src;
  src_e data_src;
  src_e next_prog_src;

  ram_port_if #(.AW(DUAL_PORT_RAM_AW), .DW(DATA_W)) dar_port ();
  ram_port_if #(.AW(SINGLE_PORT_RAM_AW), .DW(DATA_W)) sar_port ();

  // address window test
  function automatic logic in_win(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] base,
                                  input int words);
    in_win = (int'(addr) >= int'(base)) &&
             (int'(addr) < int'(base) + words);
  endfunction : in_win

  // pin synchronisers, not reset so straps are seen during reset
  always_ff @(posedge sys_clk) begin
    pin_meta <= {serial_transmit_pin, test_data_pin, device_reset_pin_n,
                 test_reset_pin, ext_debug};
    pin_sync <= pin_meta;
  end

  assign boot_strap = ~pin_sync[1] & ~pin_sync[2] & ~pin_sync[3];
  assign ext_blocked = secured & pin_sync[0];

  // boot bit caught during reset, software writable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_rom_enable <= ~boot_strap;
      boot_strap_seen <= boot_strap;
    end else if (reg_wr && reg_addr == REG_SYS_CTRL_TWO) begin
      boot_rom_enable <= reg_wdata[BOOT_EN_BIT];
    end
  end

  // multiplier strap, high or pulled up gives x4
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_mult_x4 <= pin_sync[4];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {single_port_ram_data_map, single_port_ram_program_map} <= SAR_MAP_RESET;
    end else if (reg_wr && reg_addr == REG_SYS_CTRL_TWO) begin
      single_port_ram_program_map <= reg_wdata[SAR_PROG_BIT];
      single_port_ram_data_map <= reg_wdata[SAR_DATA_BIT];
    end
  end

  // block zero space switch, instruction set beats clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      block_zero_space_select <= 1'b0;
    end else if (blk_zero_set) begin
      block_zero_space_select <= 1'b1;
    end else if (blk_zero_clr) begin
      block_zero_space_select <= 1'b0;
    end else if (reg_wr && reg_addr == REG_MEM_CTRL) begin
      block_zero_space_select <= reg_wdata[BZ_SEL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_sector_protect <= 2'b00;
    end else if (reg_wr && reg_addr == REG_MEM_CTRL) begin
      flash_sector_protect <= reg_wdata[PROT_LSB +: 2];
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      case (reg_addr)
        REG_SYS_CTRL_TWO: begin
          reg_rdata[SAR_PROG_BIT] <= single_port_ram_program_map;
          reg_rdata[SAR_DATA_BIT] <= single_port_ram_data_map;
          reg_rdata[BOOT_EN_BIT] <= boot_rom_enable;
        end
        REG_MEM_CTRL: begin
          reg_rdata[BZ_SEL_BIT] <= block_zero_space_select;
          reg_rdata[PROT_LSB +: 2] <= flash_sector_protect;
        end
        REG_STATUS: begin
          reg_rdata[STAT_SECURED_BIT] <= secured;
          reg_rdata[STAT_X4_BIT] <= pll_mult_x4;
          reg_rdata[STAT_STRAP_BIT] <= boot_strap_seen;
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // boot rom window only while boot_rom_enable is clear
  assign p_boot = ~boot_rom_enable && in_win(prog_addr, BOOT_BASE,
                                             BOOT_WORDS);
  // low flash hidden behind boot rom
  assign p_flash = ~p_boot && in_win(prog_addr, FLASH_BASE, FLASH_WORDS);
  assign p_sar = single_port_ram_program_map &&
                 in_win(prog_addr, SINGLE_PORT_RAM_PROG_BASE, SINGLE_PORT_RAM_WORDS);
  assign p_bz = block_zero_space_select &&
                in_win(prog_addr, BLK_ZERO_PROG_BASE, BLK_ZERO_WORDS);

  assign r_bz = ~block_zero_space_select &&
                in_win(data_rd_addr, BLK_ZERO_DATA_BASE, BLK_ZERO_WORDS);
  assign r_b1 = in_win(data_rd_addr, BLK_ONE_DATA_BASE, BLK_ONE_WORDS);
  assign r_b2 = in_win(data_rd_addr, BLK_TWO_DATA_BASE, BLK_TWO_WORDS);
  assign r_sar = single_port_ram_data_map &&
                 in_win(data_rd_addr, SINGLE_PORT_RAM_DATA_BASE, SINGLE_PORT_RAM_WORDS);
  assign w_bz = ~block_zero_space_select &&
                in_win(data_wr_addr, BLK_ZERO_DATA_BASE, BLK_ZERO_WORDS);
  assign w_b1 = in_win(data_wr_addr, BLK_ONE_DATA_BASE, BLK_ONE_WORDS);
  assign w_b2 = in_win(data_wr_addr, BLK_TWO_DATA_BASE, BLK_TWO_WORDS);
  assign w_sar = single_port_ram_data_map &&
                 in_win(data_wr_addr, SINGLE_PORT_RAM_DATA_BASE, SINGLE_PORT_RAM_WORDS);
  assign r_dar = r_bz | r_b1 | r_b2;

  // data address to dual ram index
  always_comb begin
    data_rd_idx = {2'b00, data_rd_addr[7:0]};
    if (r_b1) begin
      data_rd_idx = BLK_ONE_IDX | {2'b00, data_rd_addr[7:0]};
    end else if (r_b2) begin
      data_rd_idx = BLK_TWO_IDX | {5'b00000, data_rd_addr[4:0]};
    end
    data_wr_idx = {2'b00, data_wr_addr[7:0]};
    if (w_b1) begin
      data_wr_idx = BLK_ONE_IDX | {2'b00, data_wr_addr[7:0]};
    end else if (w_b2) begin
      data_wr_idx = BLK_TWO_IDX | {5'b00000, data_wr_addr[4:0]};
    end
  end

  // dual ram read and write ports, program side first
  always_comb begin
    dar_port.rd = (prog_rd & p_bz) | (data_rd & r_dar);
    dar_port.rd_addr = (prog_rd & p_bz) ? {2'b00, prog_addr[7:0]}
                                        : data_rd_idx;
    dar_port.wr = (prog_wr & p_bz) | (data_wr & (w_bz | w_b1 | w_b2));
    dar_port.wr_addr = (prog_wr & p_bz) ? {2'b00, prog_addr[7:0]}
                                        : data_wr_idx;
    dar_port.wdata = (prog_wr & p_bz) ? prog_wdata : data_wdata;
  end

  // single ram port, program side first
  always_comb begin
    sar_port.rd = (prog_rd & p_sar) | (data_rd & r_sar);
    sar_port.rd_addr = (prog_rd & p_sar) ? prog_addr[SINGLE_PORT_RAM_AW-1:0]
                                         : data_rd_addr[SINGLE_PORT_RAM_AW-1:0];
    sar_port.wr = (prog_wr & p_sar) | (data_wr & w_sar);
    sar_port.wr_addr = (prog_wr & p_sar) ? prog_addr[SINGLE_PORT_RAM_AW-1:0]
                                         : data_wr_addr[SINGLE_PORT_RAM_AW-1:0];
    sar_port.wdata = (prog_wr & p_sar) ? prog_wdata : data_wdata;
  end

  dual_access_mem #(.WORDS(DUAL_PORT_RAM_WORDS), .AW(DUAL_PORT_RAM_AW), .DW(DATA_W))
    u_dual_port_ram (
    .sys_clk(sys_clk),
    .port(dar_port)
  );

  // single-access block array
  dual_access_mem #(.WORDS(SINGLE_PORT_RAM_WORDS), .AW(SINGLE_PORT_RAM_AW), .DW(DATA_W))
    u_single_port_ram (
    .sys_clk(sys_clk),
    .port(sar_port)
  );

  // password and key-read watcher
  flash_unlock u_flash_unlock (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_rd(prog_rd),
    .prog_addr(prog_addr),
    .data_wr(data_wr),
    .data_wr_addr(data_wr_addr),
    .data_wdata(data_wdata),
    .key_words(key_words),
    .secured(secured)
  );

  // program read source
  always_comb begin
    next_prog_src = SRC_NONE;
    if (prog_rd) begin
      if (p_boot) begin
        next_prog_src = SRC_BOOT;
      end else if (p_flash) begin
        next_prog_src = ext_blocked ? SRC_ZERO : SRC_FLASH;
      end else if (p_sar) begin
        next_prog_src = SRC_SAR;
      end else if (p_bz) begin
        next_prog_src = SRC_DAR;
      end else begin
        next_prog_src = SRC_ZERO;
      end
    end
  end

  // flash and boot rom strobes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_rd <= 1'b0;
      flash_wr <= 1'b0;
      boot_rd <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= 16'h0000;
      boot_addr <= 8'h00;
    end else begin
      flash_rd <= next_prog_src == SRC_FLASH;
      flash_wr <= prog_wr && p_flash && ~ext_blocked &&
                  ~flash_sector_protect[prog_addr[SECTOR_BIT]];
      boot_rd <= next_prog_src == SRC_BOOT;
      flash_addr <= prog_addr[FLASH_AW-1:0];
      flash_wdata <= prog_wdata;
      boot_addr <= prog_addr[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_src <= SRC_NONE;
      data_src <= SRC_NONE;
    end else begin
      prog_src <= next_prog_src;
      if (!data_rd) begin
        data_src <= SRC_NONE;
      end else if (r_dar) begin
        data_src <= SRC_DAR;
      end else if (r_sar && !(prog_rd & p_sar)) begin
        data_src <= SRC_SAR;
      end else begin
        data_src <= SRC_ZERO;
      end
    end
  end

  // program read data mux
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_rdata <= 16'h0000;
      prog_rvalid <= 1'b0;
    end else begin
      prog_rvalid <= prog_src != SRC_NONE;
      case (prog_src)
        SRC_DAR: prog_rdata <= dar_port.rdata;
        SRC_SAR: prog_rdata <= sar_port.rdata;
        SRC_FLASH: prog_rdata <= flash_rdata;
        SRC_BOOT: prog_rdata <= boot_rdata;
        default: prog_rdata <= 16'h0000;
      endcase
    end
  end

  // data read data mux
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_rdata <= 16'h0000;
      data_rvalid <= 1'b0;
    end else begin
      data_rvalid <= data_src != SRC_NONE;
      case (data_src)
        SRC_DAR: data_rdata <= dar_port.rdata;
        SRC_SAR: data_rdata <= sar_port.rdata;
        default: data_rdata <= 16'h0000;
      endcase
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_secured <= 1'b1;
      boot_rom_active <= 1'b0;
    end else begin
      flash_secured <= secured;
      boot_rom_active <= ~boot_rom_enable;
    end
  end
endmodule : onchip_memory_map
`default_nettype wire

// ==== onchip_memory_map_sv_note_end.sv ====
`default_nettype wire

// ==== onchip_map_checker.sv ====
// onchip_map_checker: port timing checks for onchip_memory_map.
// assumes one sys_clk domain and synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module onchip_map_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // core buses
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_rvalid,
  input wire logic data_rd,
  input wire logic data_rvalid,
  // array side and status
  input wire logic [12:0] flash_addr,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic [1:0] flash_sector_protect,
  input wire logic boot_rd,
  input wire logic flash_secured,
  input wire logic boot_rom_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // read answers, array strobes, lock state
  property p_prog_lat; prog_rd |-> ##2 prog_rvalid; endproperty
  a_prog_lat: assert property (p_prog_lat)
    else $error("program read not answered in two cycles");
  property p_data_lat; data_rd |-> ##2 data_rvalid; endproperty
  a_data_lat: assert property (p_data_lat)
    else $error("data read not answered in two cycles");
  property p_rst_sec; disable iff (1'b0) rst |=> flash_secured; endproperty
  a_rst_sec: assert property (p_rst_sec)
    else $error("not secured after reset");
  property p_no_relock; !flash_secured |=> !flash_secured; endproperty
  a_no_relock: assert property (p_no_relock)
    else $error("lock came back without reset");
  property p_boot_win; boot_rd |-> $past(prog_rd) &&
    $past(prog_addr[15:8]) == 8'h00 && $past(boot_rom_active); endproperty
  a_boot_win: assert property (p_boot_win)
    else $error("boot rom read outside its window");
  property p_flash_addr; flash_rd |-> $past(prog_rd) &&
    $past(prog_addr[15:13]) == 3'h0 && flash_addr == $past(prog_addr[12:0]);
  endproperty
  a_flash_addr: assert property (p_flash_addr)
    else $error("flash read address wrong");
  property p_protect; flash_wr |-> !flash_sector_protect[flash_addr[12]];
  endproperty
  a_protect: assert property (p_protect)
    else $error("write reached a protected sector");
  property p_boot_hides; flash_rd && $past(boot_rom_active) |->
    flash_addr[12:8] != 5'h00; endproperty
  a_boot_hides: assert property (p_boot_hides)
    else $error("low flash read while boot rom on");
endmodule : onchip_map_checker
bind onchip_memory_map onchip_map_checker chk (.*);
`default_nettype wire

// ==== flash_boot_model.sv ====
// flash_boot_model: flash array and boot rom behind onchip_memory_map.
// assumes one-cycle strobes; read data stands while the strobe stands.
`timescale 1ns/100ps
`default_nettype none
module flash_boot_model (
  // clock
  input wire logic sys_clk,
  // flash array
  input wire logic [12:0] flash_addr,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic [15:0] flash_wdata,
  output logic [15:0] flash_rdata,
  // boot rom
  input wire logic [7:0] boot_addr,
  input wire logic boot_rd,
  output logic [15:0] boot_rdata
);
  logic [15:0] cells [0:8191];
  logic [15:0] flash_last, boot_last;
  // contents follow the address
  initial begin
    for (int i = 0; i < 8192; i++) begin
      cells[i] = {3'b101, i[12:0]};
    end
    flash_last = 16'h0000;
    boot_last = 16'h0000;
  end
  // 8K program flash, read answers while the strobe stands
  always @(posedge sys_clk) begin
    if (flash_wr) begin
      cells[flash_addr] <= flash_wdata;
    end
    if (flash_rd) begin
      flash_last <= cells[flash_addr];
    end
  end
  // idle bus shows the inverse of the last word read
  assign flash_rdata = flash_rd ? cells[flash_addr] : ~flash_last;
  always @(posedge sys_clk) begin
    if (boot_rd) begin
      boot_last <= {8'hb0, boot_addr};
    end
  end
  assign boot_rdata = boot_rd ? {8'hb0, boot_addr} : ~boot_last;
endmodule : flash_boot_model
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: core-side bus tasks driving onchip_memory_map and its arrays.
// assumes flash_boot_model answers flash and boot rom strobes.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import onchip_map_pkg::*;
();
  logic sys_clk = 1'b0, rst = 1'b1;
  logic prog_rd = 1'b0, prog_wr = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
  logic blk_zero_set = 1'b0, blk_zero_clr = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, ext_debug = 1'b0, test_reset_pin = 1'b0;
  logic test_data_pin = 1'b0, device_reset_pin_n = 1'b0;
  logic serial_transmit_pin = 1'b1;
  logic power_drive_protect_pin = 1'b1; // held high, connected to nothing
  logic [15:0] prog_addr = 16'h0000, prog_wdata = 16'h0000;
  logic [15:0] data_rd_addr = 16'h0000, data_wr_addr = 16'h0000;
  logic [15:0] data_wdata = 16'h0000, reg_wdata = 16'h0000;
  logic [1:0] reg_addr = 2'h0;
  logic [63:0] key_words = 64'h1234_5678_9abc_def0;
  logic [15:0] prog_rdata, data_rdata, flash_rdata, flash_wdata;
  logic [15:0] boot_rdata, reg_rdata;
  logic prog_rvalid, data_rvalid, flash_rd, flash_wr, boot_rd;
  logic flash_secured, pll_mult_x4, boot_rom_active;
  logic [12:0] flash_addr;
  logic [7:0] boot_addr;
  logic [1:0] flash_sector_protect;
  int num_errors = 0, checks_done = 0, cycles = 0;
  onchip_memory_map dut (.*);
  flash_boot_model far_end (.*);
  // clock and hang ceiling
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic tdi, txd, input logic [63:0] key);
    @(posedge sys_clk);
    rst <= 1'b1;
    device_reset_pin_n <= 1'b0;
    test_data_pin <= tdi;
    serial_transmit_pin <= txd;
    key_words <= key;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    device_reset_pin_n <= 1'b1;
    @(posedge sys_clk);
    #1;
  endtask : do_reset
  // program access; d is write data or expected read data
  task automatic pacc(input logic w, input logic [15:0] a, d,
                      input logic chk);
    @(posedge sys_clk);
    prog_rd <= ~w;
    prog_wr <= w;
    prog_addr <= a;
    prog_wdata <= d;
    @(posedge sys_clk);
    prog_rd <= 1'b0;
    prog_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
    if (chk) begin
      `CHK(prog_rvalid, 1'b1)
      `CHK(prog_rdata, d)
    end
  endtask : pacc
  // data write and read in the same cycle
  task automatic dacc(input logic w, input logic [15:0] wa, wd,
                      input logic r, input logic [15:0] ra, e);
    @(posedge sys_clk);
    data_wr <= w;
    data_wr_addr <= wa;
    data_wdata <= wd;
    data_rd <= r;
    data_rd_addr <= ra;
    @(posedge sys_clk);
    data_wr <= 1'b0;
    data_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    if (r) begin
      `CHK(data_rvalid, 1'b1)
      `CHK(data_rdata, e)
    end
  endtask : dacc
  task automatic racc(input logic w, input logic [1:0] a,
                      input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w) begin
      `CHK(reg_rdata, d)
    end
  endtask : racc
  task automatic bz(input logic s);
    @(posedge sys_clk);
    blk_zero_set <= s;
    blk_zero_clr <= ~s;
    @(posedge sys_clk);
    blk_zero_set <= 1'b0;
    blk_zero_clr <= 1'b0;
  endtask : bz
  // key reads, then password words with one word spoilt at index bad
  task automatic unlock(input int bad, input logic wr);
    for (int i = 0; i < 4; i++) begin
      pacc(1'b0, KEY_READ_BASE + 16'(i), 16'h0000, 1'b0);
    end
    for (int i = 0; i < 4 && wr; i++) begin
      dacc(1'b1, PASSWORD_BASE + 16'(i), key_words[16*i +: 16] ^
           16'(i == bad), 1'b0, 16'h0000, 16'h0000);
    end
  endtask : unlock
  // lead: edges still to pass before the lock drops on the next one
  task automatic drop_lock(input int lead);
    repeat (lead) @(posedge sys_clk);
    #1;
    `CHK(flash_secured, 1'b1)
    @(posedge sys_clk);
    #1;
    `CHK(flash_secured, 1'b0)
  endtask : drop_lock
  // main sequence
  initial begin
    do_reset(1'b0, 1'b1, 64'h1234_5678_9abc_def0);
    `CHK(flash_secured, 1'b1)
    `CHK(pll_mult_x4, 1'b1)
    `CHK(boot_rom_active, 1'b1)
    racc(1'b0, 2'h0, 16'h0003);
    racc(1'b0, 2'h1, 16'h0000);
    racc(1'b0, 2'h3, 16'h0000);
    pacc(1'b0, 16'h0010, 16'hb010, 1'b1);
    pacc(1'b0, 16'h00ff, 16'hb0ff, 1'b1);
    pacc(1'b0, 16'h0100, 16'ha100, 1'b1);
    pacc(1'b0, 16'h1fff, 16'hbfff, 1'b1);
    $display("test reset and boot done");
    dacc(1'b1, 16'h0300, 16'h1111, 1'b0, 16'h0000, 16'h0000);
    dacc(1'b1, 16'h0060, 16'h2222, 1'b1, 16'h0300, 16'h1111);
    dacc(1'b1, 16'h007f, 16'h3333, 1'b1, 16'h0060, 16'h2222);
    dacc(1'b1, 16'h0205, 16'h4444, 1'b1, 16'h007f, 16'h3333);
    bz(1'b1);
    pacc(1'b0, 16'hfe05, 16'h4444, 1'b1);
    dacc(1'b0, 16'h0000, 16'h0000, 1'b1, 16'h0205, 16'h0000);
    racc(1'b0, 2'h1, 16'h0001);
    bz(1'b0);
    dacc(1'b1, 16'h0800, 16'h5555, 1'b1, 16'h0205, 16'h4444);
    $display("test dual ram done");
    pacc(1'b0, 16'h8000, 16'h5555, 1'b1);
    pacc(1'b1, 16'h81ff, 16'h6666, 1'b0);
    racc(1'b1, 2'h0, 16'h0001);
    dacc(1'b0, 16'h0000, 16'h0000, 1'b1, 16'h09ff, 16'h0000);
    racc(1'b1, 2'h0, 16'h0002);
    dacc(1'b0, 16'h0000, 16'h0000, 1'b1, 16'h09ff, 16'h6666);
    pacc(1'b0, 16'h8000, 16'h0000, 1'b1);
    $display("test single ram done");
    racc(1'b1, 2'h0, 16'h000b);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(boot_rom_active, 1'b0)
    pacc(1'b0, 16'h0010, 16'ha010, 1'b1);
    racc(1'b1, 2'h1, 16'h0002);
    repeat (2) @(posedge sys_clk);
    `CHK(flash_sector_protect, 2'b01)
    pacc(1'b1, 16'h0105, 16'h7777, 1'b0);
    pacc(1'b1, 16'h1105, 16'h8888, 1'b0);
    pacc(1'b0, 16'h0105, 16'ha105, 1'b1);
    pacc(1'b0, 16'h1105, 16'h8888, 1'b1);
    $display("test flash map done");
    @(posedge sys_clk);
    ext_debug <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pacc(1'b0, 16'h1105, 16'h0000, 1'b1);
    unlock(2, 1'b1);
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(flash_secured, 1'b1)
    unlock(4, 1'b1);
    drop_lock(0);
    pacc(1'b0, 16'h1105, 16'h8888, 1'b1);
    $display("test password done");
    do_reset(1'b1, 1'b0, 64'h0000_0000_0000_0000);
    `CHK(flash_secured, 1'b1)
    `CHK(pll_mult_x4, 1'b0)
    `CHK(boot_rom_active, 1'b0)
    racc(1'b0, 2'h0, 16'h000b);
    racc(1'b1, 2'h0, 16'h0003);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(boot_rom_active, 1'b1)
    unlock(4, 1'b0);
    drop_lock(1);
    $display("test trivial key done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
